// ===== include/i2s_fifo_pkg.sv
package i2s_fifo_pkg;
  // ****************
  // register offsets
  // ****************
  localparam logic [11:0] TX_OVERRUN_CLEAR_OFS = 12'h044;
  localparam logic [11:0] RX_FIFO_THRESHOLD_CFG_OFS = 12'h048;
  localparam logic [11:0] TX_FIFO_THRESHOLD_CFG_OFS = 12'h04c;
  localparam logic [11:0] RX_FIFO_FLUSH_OFS = 12'h050;
  localparam logic [11:0] TX_FIFO_FLUSH_OFS = 12'h054;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h058;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h05c;
  localparam logic [11:0] FIFO_STATE_OFS = 12'h060;
  localparam logic [11:0] RX_BLOCK_DMA_PORT_OFS = 12'h1c0;
  localparam logic [11:0] TX_BLOCK_DMA_PORT_OFS = 12'h1c8;
  // ****************
  // fields and reset values
  // ****************
  localparam logic [3:0] RX_THRESHOLD_RST = 4'h4;
  localparam logic [3:0] TX_THRESHOLD_RST = 4'h3;
  localparam logic [3:0] THRESHOLD_MAX = 4'h7;
  localparam logic [5:0] IRQ_MASK_RST = 6'h00;
  localparam int RX_AVAIL_BIT = 0;
  localparam int RX_OVERRUN_BIT = 1;
  localparam int TX_EMPTY_BIT = 4;
  localparam int TX_OVERRUN_BIT = 5;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : i2s_fifo_pkg

// ===== sim/serial_far_end.sv
`timescale 1ns/1ns
// ****************
// serial side: receiver feeding rx words, transmitter taking tx words
// ****************
module serial_far_end (
  input wire logic clk,
  output logic push,
  output logic [31:0] push_data,
  output logic pop,
  input wire logic pop_valid,
  input wire logic [31:0] pop_data
);
  initial
  begin
    push = 1'b0;
    push_data = 32'h0;
    pop = 1'b0;
  end
  task automatic send(input logic [31:0] d, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    push <= 1'b1;
    push_data <= d;
    @(posedge clk);
    push <= 1'b0;
    // stale word inverted so a late sample cannot pass for fresh data
    push_data <= ~d;
  endtask : send
  task automatic take(output logic [31:0] d, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    pop <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!pop_valid && n < 20);
    d = pop_data;
    ok = pop_valid;
    pop <= 1'b0;
  endtask : take
endmodule : serial_far_end

// ===== sim/test_i2s_fifo_ctrl.sv
`timescale 1ns/1ns
module test_i2s_fifo_ctrl;
  logic MCLK, RESET_N, CE, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, ok;
  logic RX_CHANNEL_ENABLE, TX_CHANNEL_ENABLE, RX_PUSH, TX_POP, TX_POP_VALID, RX_AVAIL, TX_EMPTY_TH, IRQ;
  logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, RX_PUSH_DATA, TX_POP_DATA, q, w;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
  logic [31:0] rxq[$], txq[$];
  int num_errors = 0;
  int n_compared = 0;
  int rx_thr, tx_thr;
  i2s_fifo_ctrl DUT (.MCLK(MCLK), .RESET_N(RESET_N), .CE(CE), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .RX_CHANNEL_ENABLE(RX_CHANNEL_ENABLE), .TX_CHANNEL_ENABLE(TX_CHANNEL_ENABLE),
    .RX_PUSH(RX_PUSH), .RX_PUSH_DATA(RX_PUSH_DATA), .TX_POP(TX_POP), .TX_POP_VALID(TX_POP_VALID),
    .TX_POP_DATA(TX_POP_DATA), .RX_AVAIL(RX_AVAIL), .TX_EMPTY_TH(TX_EMPTY_TH), .IRQ(IRQ));
  serial_far_end far (.clk(MCLK), .push(RX_PUSH), .push_data(RX_PUSH_DATA), .pop(TX_POP),
    .pop_valid(TX_POP_VALID), .pop_data(TX_POP_DATA));
  // ****************
  // reporting and bus access
  // ****************
  task automatic conclude;
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : cmp_word
  task automatic cmp_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : cmp_flag
  task automatic bus(input bit wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic [1:0] c);
    int n;
    n = 0;
    @(posedge MCLK);
    S_AXI_AWADDR <= a;
    S_AXI_ARADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= wr;
    S_AXI_WVALID <= wr;
    S_AXI_BREADY <= wr;
    S_AXI_ARVALID <= !wr;
    S_AXI_RREADY <= !wr;
    do
    begin
      @(posedge MCLK);
      n++;
    end
    while (!(wr ? S_AXI_AWREADY && S_AXI_WREADY : S_AXI_ARREADY) && n < 50);
    S_AXI_AWVALID <= 1'b0;
    S_AXI_WVALID <= 1'b0;
    S_AXI_ARVALID <= 1'b0;
    do
    begin
      @(posedge MCLK);
      n++;
    end
    while (!(wr ? S_AXI_BVALID : S_AXI_RVALID) && n < 100);
    r = S_AXI_RDATA;
    c = wr ? S_AXI_BRESP : S_AXI_RRESP;
    S_AXI_BREADY <= 1'b0;
    S_AXI_RREADY <= 1'b0;
    if (n >= 100)
    begin
      cmp_flag(1'b0, 1'b1);
      conclude;
    end
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic [1:0] c;
    bus(1'b1, a, d, r, c);
    cmp_word({30'h0, c}, {30'h0, i2s_fifo_pkg::RESP_OKAY});
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic [1:0] c;
    bus(1'b0, a, 32'h0, r, c);
    cmp_word({30'h0, c}, {30'h0, i2s_fifo_pkg::RESP_OKAY});
  endtask : rd
  task automatic set_en(input logic rx, input logic tx);
    @(posedge MCLK);
    RX_CHANNEL_ENABLE <= rx;
    TX_CHANNEL_ENABLE <= tx;
  endtask : set_en
  initial
  begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  // ****************
  // scenarios
  // ****************
  initial
  begin
    {RESET_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h00;
    {RX_CHANNEL_ENABLE, TX_CHANNEL_ENABLE, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 58'h0;
    CE = 1'b1;
    S_AXI_WSTRB = 4'hf;
    w = $urandom(83);
    repeat (20) @(posedge MCLK);
    RESET_N <= 1'b1;
    rd(i2s_fifo_pkg::TX_OVERRUN_CLEAR_OFS, q);
    cmp_word(q, 32'h1);
    bus(1'b0, 12'h0f0, 32'h0, q, resp);
    cmp_word({30'h0, resp}, {30'h0, i2s_fifo_pkg::RESP_SLVERR});
    for (int v = 0; v < 16; v++)
    begin
      w = {28'($urandom), 4'(v)};
      wr(i2s_fifo_pkg::RX_FIFO_THRESHOLD_CFG_OFS, w);
      rd(i2s_fifo_pkg::RX_FIFO_THRESHOLD_CFG_OFS, q);
      cmp_word(q & 32'hf, 32'(v > 7 ? 7 : v));
      wr(i2s_fifo_pkg::TX_FIFO_THRESHOLD_CFG_OFS, w);
      rd(i2s_fifo_pkg::TX_FIFO_THRESHOLD_CFG_OFS, q);
      cmp_word(q & 32'hf, 32'(v > 7 ? 7 : v));
    end
    rx_thr = $urandom_range(7);
    wr(i2s_fifo_pkg::RX_FIFO_THRESHOLD_CFG_OFS, 32'(rx_thr));
    set_en(1'b1, 1'b0);
    for (int i = 0; i < 9; i++)
    begin
      w = $urandom;
      far.send(w, $urandom_range(3));
      if (rxq.size() < i2s_fifo_pkg::FIFO_DEPTH)
        rxq.push_back(w);
      #1;
      cmp_flag(RX_AVAIL, rxq.size() >= rx_thr + 1);
    end
    rd(i2s_fifo_pkg::IRQ_STATUS_OFS, q);
    cmp_flag(q[i2s_fifo_pkg::RX_OVERRUN_BIT], 1'b1);
    for (int i = 0; i < 9; i++)
    begin
      rd(i2s_fifo_pkg::RX_BLOCK_DMA_PORT_OFS, q);
      cmp_word(q, rxq.size() > 0 ? rxq.pop_front() : 32'h0);
    end
    set_en(1'b0, 1'b0);
    wr(i2s_fifo_pkg::RX_FIFO_THRESHOLD_CFG_OFS, 32'h0);
    set_en(1'b1, 1'b0);
    repeat (3) far.send($urandom, 0);
    #1;
    cmp_flag(RX_AVAIL, 1'b1);
    rd(i2s_fifo_pkg::RX_BLOCK_DMA_PORT_OFS, q);
    rd(i2s_fifo_pkg::FIFO_STATE_OFS, q);
    cmp_word(q & 32'h1000f, 32'h10002);
    set_en(1'b0, 1'b0);
    wr(i2s_fifo_pkg::RX_FIFO_FLUSH_OFS, 32'h1);
    cmp_flag(RX_AVAIL, 1'b0);
    rd(i2s_fifo_pkg::FIFO_STATE_OFS, q);
    cmp_word(q & 32'h1000f, 32'h0);
    rd(i2s_fifo_pkg::RX_FIFO_FLUSH_OFS, q);
    cmp_word(q, 32'h0);
    set_en(1'b1, 1'b0);
    CE <= 1'b0;
    far.send($urandom, 0);
    CE <= 1'b1;
    rd(i2s_fifo_pkg::FIFO_STATE_OFS, q);
    cmp_word(q & 32'hf, 32'h0);
    set_en(1'b0, 1'b0);
    tx_thr = $urandom_range(7);
    wr(i2s_fifo_pkg::TX_FIFO_THRESHOLD_CFG_OFS, 32'(tx_thr));
    for (int i = 0; i < 9; i++)
    begin
      w = $urandom;
      wr(i2s_fifo_pkg::TX_BLOCK_DMA_PORT_OFS, w);
      if (txq.size() < i2s_fifo_pkg::FIFO_DEPTH)
        txq.push_back(w);
      cmp_flag(TX_EMPTY_TH, txq.size() <= tx_thr);
    end
    rd(i2s_fifo_pkg::TX_OVERRUN_CLEAR_OFS, q);
    cmp_word(q, 32'h0);
    rd(i2s_fifo_pkg::TX_OVERRUN_CLEAR_OFS, q);
    cmp_word(q, 32'h1);
    wr(i2s_fifo_pkg::TX_BLOCK_DMA_PORT_OFS, $urandom);
    wr(i2s_fifo_pkg::IRQ_MASK_OFS, 32'h13);
    cmp_flag(IRQ, 1'b1);
    wr(i2s_fifo_pkg::IRQ_MASK_OFS, 32'h33);
    cmp_flag(IRQ, 1'b0);
    wr(i2s_fifo_pkg::IRQ_MASK_OFS, 32'h13);
    wr(i2s_fifo_pkg::IRQ_STATUS_OFS, 32'h20);
    cmp_flag(IRQ, 1'b0);
    set_en(1'b0, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      far.take(q, ok);
      cmp_flag(ok, 1'b1);
      if (!ok)
        conclude;
      cmp_word(q, txq.pop_front());
    end
    #1;
    cmp_flag(TX_EMPTY_TH, 1'b1);
    set_en(1'b0, 1'b0);
    repeat (3) wr(i2s_fifo_pkg::TX_BLOCK_DMA_PORT_OFS, $urandom);
    rd(i2s_fifo_pkg::FIFO_STATE_OFS, q);
    cmp_word(q & 32'h20f00, 32'h20300);
    wr(i2s_fifo_pkg::TX_FIFO_FLUSH_OFS, 32'h1);
    cmp_flag(TX_EMPTY_TH, 1'b1);
    rd(i2s_fifo_pkg::FIFO_STATE_OFS, q);
    cmp_word(q & 32'h20f00, 32'h0);
    rd(i2s_fifo_pkg::TX_FIFO_FLUSH_OFS, q);
    cmp_word(q, 32'h0);
    set_en(1'b0, 1'b1);
    @(posedge MCLK);
    #1;
    cmp_flag(TX_POP_VALID, 1'b0);
    conclude;
  end
endmodule : test_i2s_fifo_ctrl

// ===== verilog/i2s_fifo_ctrl.sv
`timescale 1ns/1ns
// Functional notes
// - reading the tx overrun clear register clears the pending tx overrun condition.
// - that register's bit 0 reads 1 when no tx overrun, 0 when one is pending.
// - rx data available raised when rx fifo holds threshold plus one entries.
// - rx threshold writes above 7 store and read back 7.
// - tx empty trigger level equals programmed value; illegal values saturate to 7.
// - writing 1 to rx flush bit empties rx fifo; bit reads back 0.
// - writing 1 to tx flush bit empties tx fifo; bit clears itself.
// - rx dma port reads step through enabled channel, left then right words.
// - tx dma port writes fill enabled channel, left then right, wrapping.
// - a tx write to a full fifo flags tx overrun.
// - rx data lost on a full rx fifo flags rx overrun.
module i2s_fifo_ctrl (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic RX_CHANNEL_ENABLE,
  input wire logic TX_CHANNEL_ENABLE,
  input wire logic RX_PUSH,
  input wire logic [31:0] RX_PUSH_DATA,
  input wire logic TX_POP,
  output logic TX_POP_VALID,
  output logic [31:0] TX_POP_DATA,
  output logic RX_AVAIL,
  output logic TX_EMPTY_TH,
  output logic IRQ
);
  // ****************
  // state
  // ****************
  logic [31:0] rx_mem [i2s_fifo_pkg::FIFO_DEPTH];
  logic [31:0] tx_mem [i2s_fifo_pkg::FIFO_DEPTH];
  logic [i2s_fifo_pkg::PTR_W-1:0] rx_wp_reg, rx_rp_reg, tx_wp_reg, tx_rp_reg;
  logic [i2s_fifo_pkg::CNT_W-1:0] rx_cnt_reg, tx_cnt_reg, rx_cnt_next, tx_cnt_next;
  logic [3:0] rx_avail_threshold_reg, tx_empty_threshold_reg;
  logic [5:0] ist_reg, ist_next, mask_reg;
  logic rx_side_reg, tx_side_reg;
  logic bvalid_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // ****************
  // bus decode
  // ****************
  // ready waits for the enable, so a frozen block never completes a handshake it cannot act on
  wire wr_go = CE & S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_reg;
  wire rd_go = CE & S_AXI_ARVALID & ~rvalid_reg;
  wire [11:0] wa = S_AXI_AWADDR;
  wire [11:0] ra = S_AXI_ARADDR;
  wire lane0 = S_AXI_WSTRB[0];
  wire w_rx_th = wr_go & (wa == i2s_fifo_pkg::RX_FIFO_THRESHOLD_CFG_OFS);
  wire w_tx_th = wr_go & (wa == i2s_fifo_pkg::TX_FIFO_THRESHOLD_CFG_OFS);
  wire w_rx_fl = wr_go & (wa == i2s_fifo_pkg::RX_FIFO_FLUSH_OFS);
  wire w_tx_fl = wr_go & (wa == i2s_fifo_pkg::TX_FIFO_FLUSH_OFS);
  wire w_ist = wr_go & (wa == i2s_fifo_pkg::IRQ_STATUS_OFS);
  wire w_mask = wr_go & (wa == i2s_fifo_pkg::IRQ_MASK_OFS);
  wire w_txd = wr_go & (wa == i2s_fifo_pkg::TX_BLOCK_DMA_PORT_OFS);
  wire w_ro = (wa == i2s_fifo_pkg::TX_OVERRUN_CLEAR_OFS) | (wa == i2s_fifo_pkg::FIFO_STATE_OFS)
    | (wa == i2s_fifo_pkg::RX_BLOCK_DMA_PORT_OFS);
  wire w_ok = w_rx_th | w_tx_th | w_rx_fl | w_tx_fl | w_ist | w_mask | w_txd | (wr_go & w_ro);
  wire r_tor = rd_go & (ra == i2s_fifo_pkg::TX_OVERRUN_CLEAR_OFS);
  wire r_rxd = rd_go & (ra == i2s_fifo_pkg::RX_BLOCK_DMA_PORT_OFS);

  // ****************
  // fifo control
  // ****************
  wire rx_flush = w_rx_fl & lane0 & S_AXI_WDATA[0];
  wire tx_flush = w_tx_fl & lane0 & S_AXI_WDATA[0];
  wire rx_full = rx_cnt_reg == i2s_fifo_pkg::CNT_W'(i2s_fifo_pkg::FIFO_DEPTH);
  wire tx_full = tx_cnt_reg == i2s_fifo_pkg::CNT_W'(i2s_fifo_pkg::FIFO_DEPTH);
  wire rx_empty = rx_cnt_reg == '0;
  wire tx_empty = tx_cnt_reg == '0;
  wire rx_in = RX_PUSH & RX_CHANNEL_ENABLE;
  wire rx_wr = rx_in & ~rx_full & ~rx_flush;
  wire rx_lost = rx_in & rx_full;
  wire rx_rd = r_rxd & ~rx_empty & ~rx_flush;
  wire tx_wr = w_txd & ~tx_full & ~tx_flush;
  wire tx_lost = w_txd & tx_full;
  wire tx_rd = TX_POP & TX_POP_VALID & ~tx_flush;
  wire [3:0] wsat = (S_AXI_WDATA[3:0] > i2s_fifo_pkg::THRESHOLD_MAX) ? i2s_fifo_pkg::THRESHOLD_MAX
    : S_AXI_WDATA[3:0];
  wire [i2s_fifo_pkg::CNT_W-1:0] rx_level = rx_avail_threshold_reg + 4'h1;

  always_comb
  begin
    rx_cnt_next = rx_cnt_reg;
    if (rx_flush)
      rx_cnt_next = '0;
    else if (rx_wr & ~rx_rd)
      rx_cnt_next = rx_cnt_reg + 4'h1;
    else if (rx_rd & ~rx_wr)
      rx_cnt_next = rx_cnt_reg - 4'h1;
    tx_cnt_next = tx_cnt_reg;
    if (tx_flush)
      tx_cnt_next = '0;
    else if (tx_wr & ~tx_rd)
      tx_cnt_next = tx_cnt_reg + 4'h1;
    else if (tx_rd & ~tx_wr)
      tx_cnt_next = tx_cnt_reg - 4'h1;
  end

  assign RX_AVAIL = rx_cnt_reg >= rx_level;
  assign TX_EMPTY_TH = tx_cnt_reg <= tx_empty_threshold_reg;
  // a pop offered while frozen would hand out a word twice
  assign TX_POP_VALID = CE & TX_CHANNEL_ENABLE & ~tx_empty;
  assign TX_POP_DATA = tx_mem[tx_rp_reg];

  // ****************
  // interrupt status
  // ****************
  wire [5:0] ev = {tx_lost, TX_EMPTY_TH, 2'b00, rx_lost, RX_AVAIL};
  wire [5:0] w1c = (w_ist & lane0) ? S_AXI_WDATA[5:0] : 6'h00;
  wire [5:0] rclr = r_tor ? 6'h20 : 6'h00;
  // an event in the clearing cycle wins over the clear
  assign ist_next = (ist_reg & ~w1c & ~rclr) | ev;
  assign IRQ = |(ist_reg & ~mask_reg);

  // ****************
  // read mux
  // ****************
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (ra)
      i2s_fifo_pkg::TX_OVERRUN_CLEAR_OFS: rd_mux = {31'h0, ~ist_reg[i2s_fifo_pkg::TX_OVERRUN_BIT]};
      i2s_fifo_pkg::RX_FIFO_THRESHOLD_CFG_OFS: rd_mux = {28'h0, rx_avail_threshold_reg};
      i2s_fifo_pkg::TX_FIFO_THRESHOLD_CFG_OFS: rd_mux = {28'h0, tx_empty_threshold_reg};
      i2s_fifo_pkg::RX_FIFO_FLUSH_OFS: rd_mux = 32'h0000_0000;
      i2s_fifo_pkg::TX_FIFO_FLUSH_OFS: rd_mux = 32'h0000_0000;
      i2s_fifo_pkg::IRQ_STATUS_OFS: rd_mux = {26'h0, ist_reg};
      i2s_fifo_pkg::IRQ_MASK_OFS: rd_mux = {26'h0, mask_reg};
      i2s_fifo_pkg::FIFO_STATE_OFS: rd_mux = {14'h0, tx_side_reg, rx_side_reg, 4'h0, tx_cnt_reg, 4'h0, rx_cnt_reg};
      i2s_fifo_pkg::RX_BLOCK_DMA_PORT_OFS: rd_mux = rx_empty ? 32'h0000_0000 : rx_mem[rx_rp_reg];
      i2s_fifo_pkg::TX_BLOCK_DMA_PORT_OFS: rd_mux = 32'h0000_0000;
      default: rd_hit = 1'b0;
    endcase
  end

  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY = wr_go;
  assign S_AXI_ARREADY = rd_go;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign S_AXI_RDATA = rdata_reg;

  // ****************
  // registers
  // ****************
  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      bresp_reg <= i2s_fifo_pkg::RESP_OKAY;
      rresp_reg <= i2s_fifo_pkg::RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      rx_avail_threshold_reg <= i2s_fifo_pkg::RX_THRESHOLD_RST;
      tx_empty_threshold_reg <= i2s_fifo_pkg::TX_THRESHOLD_RST;
      mask_reg <= i2s_fifo_pkg::IRQ_MASK_RST;
      ist_reg <= 6'h00;
    end
    else if (CE)
    begin
      if (wr_go)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= w_ok ? i2s_fifo_pkg::RESP_OKAY : i2s_fifo_pkg::RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
        bvalid_reg <= 1'b0;
      if (rd_go)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_hit ? i2s_fifo_pkg::RESP_OKAY : i2s_fifo_pkg::RESP_SLVERR;
      end
      else if (S_AXI_RREADY)
        rvalid_reg <= 1'b0;
      if (w_rx_th & lane0)
        rx_avail_threshold_reg <= wsat;
      if (w_tx_th & lane0)
        tx_empty_threshold_reg <= wsat;
      if (w_mask & lane0)
        mask_reg <= S_AXI_WDATA[5:0];
      ist_reg <= ist_next;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      tx_wp_reg <= '0;
      tx_rp_reg <= '0;
      rx_cnt_reg <= '0;
      tx_cnt_reg <= '0;
      rx_side_reg <= 1'b0;
      tx_side_reg <= 1'b0;
    end
    else if (CE)
    begin
      rx_cnt_reg <= rx_cnt_next;
      tx_cnt_reg <= tx_cnt_next;
      if (rx_flush)
      begin
        rx_wp_reg <= '0;
        rx_rp_reg <= '0;
        rx_side_reg <= 1'b0;
      end
      else
      begin
        if (rx_wr)
          rx_wp_reg <= rx_wp_reg + 3'h1;
        if (rx_rd)
        begin
          rx_rp_reg <= rx_rp_reg + 3'h1;
          rx_side_reg <= ~rx_side_reg;
        end
      end
      if (tx_flush)
      begin
        tx_wp_reg <= '0;
        tx_rp_reg <= '0;
        tx_side_reg <= 1'b0;
      end
      else
      begin
        if (tx_wr)
        begin
          tx_wp_reg <= tx_wp_reg + 3'h1;
          tx_side_reg <= ~tx_side_reg;
        end
        if (tx_rd)
          tx_rp_reg <= tx_rp_reg + 3'h1;
      end
    end
  end

  // storage carries no reset; only pointers define its contents
  always_ff @(posedge MCLK)
  begin
    if (CE & rx_wr)
      rx_mem[rx_wp_reg] <= RX_PUSH_DATA;
    if (CE & tx_wr)
      tx_mem[tx_wp_reg] <= S_AXI_WDATA;
  end

  // ****************
  // assertions
  // ****************
  sequence s_rx_flush;
    CE && rx_flush;
  endsequence
  sequence s_rx_cleared;
    rx_cnt_reg == '0 && !RX_AVAIL;
  endsequence
  property p_tor_clear;
    @(posedge MCLK) disable iff (!RESET_N) CE && r_tor && !tx_lost |=> !ist_reg[5];
  endproperty
  a_tor_clear: assert property (p_tor_clear) else $error("tx overrun not cleared by read");
  property p_tor_value;
    @(posedge MCLK) disable iff (!RESET_N) CE && r_tor |=> S_AXI_RDATA[0] == !$past(ist_reg[5]);
  endproperty
  a_tor_value: assert property (p_tor_value) else $error("tx overrun clear bit wrong");
  property p_rx_avail;
    @(posedge MCLK) disable iff (!RESET_N) (rx_cnt_reg == rx_avail_threshold_reg + 4'h1) |-> RX_AVAIL;
  endproperty
  a_rx_avail: assert property (p_rx_avail) else $error("rx available missing at level");
  property p_rx_sat;
    @(posedge MCLK) disable iff (!RESET_N) CE && w_rx_th && lane0 && S_AXI_WDATA[3:0] > 4'h7
      |=> rx_avail_threshold_reg == 4'h7;
  endproperty
  a_rx_sat: assert property (p_rx_sat) else $error("rx threshold not saturated");
  property p_tx_sat;
    @(posedge MCLK) disable iff (!RESET_N) CE && w_tx_th && lane0
      |=> tx_empty_threshold_reg == ($past(S_AXI_WDATA[3:0]) > 4'h7 ? 4'h7 : $past(S_AXI_WDATA[3:0]));
  endproperty
  a_tx_sat: assert property (p_tx_sat) else $error("tx threshold out of range");
  property p_rx_flush;
    @(posedge MCLK) disable iff (!RESET_N) s_rx_flush |=> s_rx_cleared;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("rx flush left data");
  property p_tx_flush;
    @(posedge MCLK) disable iff (!RESET_N) CE && tx_flush |=> tx_cnt_reg == '0 && !TX_POP_VALID;
  endproperty
  a_tx_flush: assert property (p_tx_flush) else $error("tx flush left data");
  property p_tx_ovr;
    @(posedge MCLK) disable iff (!RESET_N) CE && w_txd && tx_full |=> ist_reg[5] && tx_cnt_reg != '0;
  endproperty
  a_tx_ovr: assert property (p_tx_ovr) else $error("tx overrun not flagged");
  property p_rx_ovr;
    @(posedge MCLK) disable iff (!RESET_N) CE && rx_in && rx_full |=> ist_reg[1];
  endproperty
  a_rx_ovr: assert property (p_rx_ovr) else $error("rx overrun not flagged");
  property p_rx_step;
    @(posedge MCLK) disable iff (!RESET_N) CE && rx_rd && !rx_wr |=> rx_cnt_reg == $past(rx_cnt_reg) - 4'h1
      && rx_side_reg != $past(rx_side_reg);
  endproperty
  a_rx_step: assert property (p_rx_step) else $error("rx dma read did not step");
  property p_tx_fill;
    @(posedge MCLK) disable iff (!RESET_N) CE && tx_wr && !tx_rd |=> tx_cnt_reg == $past(tx_cnt_reg) + 4'h1;
  endproperty
  a_tx_fill: assert property (p_tx_fill) else $error("tx dma write not stored");
  property p_tx_empty;
    @(posedge MCLK) disable iff (!RESET_N) tx_cnt_reg > tx_empty_threshold_reg |-> !TX_EMPTY_TH;
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty trigger above level");
  property p_ce_hold;
    @(posedge MCLK) disable iff (!RESET_N) !CE |=> $stable(rx_cnt_reg) && $stable(tx_cnt_reg) && $stable(ist_reg);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("state moved while clock enable low");
endmodule : i2s_fifo_ctrl
